/* File: logic/t2f_defs.svh */
// Constants of the T2 M-frame framer: frame geometry and fixed overhead values.
`ifndef T2F_DEFS_SVH
`define T2F_DEFS_SVH

`define T2F_LAST_BIT 6'h30
`define T2F_LAST_BLK 3'h5
`define T2F_LAST_SUB 2'h3

`define T2F_BLK_M  3'h0
`define T2F_BLK_C1 3'h1
`define T2F_BLK_F1 3'h2
`define T2F_BLK_C2 3'h3
`define T2F_BLK_C3 3'h4
`define T2F_BLK_F2 3'h5
`define T2F_BLK_STUFF 3'h5

`define T2F_M1_VAL 1'b0
`define T2F_M2_VAL 1'b1
`define T2F_M3_VAL 1'b1
`define T2F_F1_VAL 1'b0
`define T2F_F2_VAL 1'b1
`define T2F_STUFF_VAL 1'b0

`define T2F_FIND_CNT 8
`define T2F_M_FIND_CNT 3
`define T2F_LOSS_CNT 3
`define T2F_M_MISS_CNT 4

`endif

/* File: logic/t2f_pkg.sv */
// Types shared by the T2 M-frame framer modules.
`default_nettype none
package t2f_pkg;
  typedef logic [5:0] t2f_bit_t;
  typedef logic [2:0] t2f_blk_t;
  typedef logic [1:0] t2f_sub_t;
  typedef enum logic [1:0] {
    T2F_HUNT,
    T2F_MSYNC,
    T2F_SYNC
  } t2f_align_state_t;
endpackage
`default_nettype wire

/* File: logic/t2f_rx_align.sv */
// Receive alignment: finds F and M patterns and tracks the bit position.
`timescale 1ns/10ps
`default_nettype none
`include "t2f_defs.svh"
module t2f_rx_align #(
  parameter int FIND_CNT   = `T2F_FIND_CNT,
  parameter int M_FIND_CNT = `T2F_M_FIND_CNT,
  parameter int LOSS_CNT   = `T2F_LOSS_CNT
) (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          rx_data_i,
  output t2f_pkg::t2f_bit_t  bit_o,
  output t2f_pkg::t2f_blk_t  blk_o,
  output t2f_pkg::t2f_sub_t  sub_o,
  output logic               in_frame_o,
  output logic               lof_o
);
  t2f_pkg::t2f_align_state_t state_r;
  t2f_pkg::t2f_bit_t         bit_r;
  t2f_pkg::t2f_blk_t         blk_r;
  t2f_pkg::t2f_sub_t         sub_r;
  logic [7:0]                cnt_r;
  logic                      is_f;
  logic                      f_ok;
  logic                      is_m;
  logic                      m_ok;
  logic                      slip;
  logic                      give_up;
  logic [7:0]                miss_r;
  // A false lock on payload that mimics the F pattern never sees good M bits,
  // so too many M misses send the search back to hunting one bit later.
  localparam int M_MISS_CNT = `T2F_M_MISS_CNT;

  assign is_f = (bit_r == 6'h00) && (blk_r == `T2F_BLK_F1 || blk_r == `T2F_BLK_F2);
  assign f_ok = rx_data_i == ((blk_r == `T2F_BLK_F1) ? `T2F_F1_VAL : `T2F_F2_VAL);
  // The fourth subframe's M position carries the alarm bit, so it is never checked.
  assign is_m = (bit_r == 6'h00) && (blk_r == `T2F_BLK_M) && (sub_r != `T2F_LAST_SUB);
  assign m_ok = rx_data_i == ((sub_r == 2'h0) ? `T2F_M1_VAL :
                              (sub_r == 2'h1) ? `T2F_M2_VAL : `T2F_M3_VAL);
  // A failed F check while hunting holds the counter for one bit, sliding the guess.
  assign give_up = (state_r == t2f_pkg::T2F_MSYNC) && is_m && !m_ok &&
                   (miss_r == 8'(M_MISS_CNT - 1));
  assign slip = ((state_r == t2f_pkg::T2F_HUNT) && is_f && !f_ok) || give_up;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_r <= 6'h00;
      blk_r <= 3'h0;
    end else if (!slip) begin
      if (bit_r == `T2F_LAST_BIT) begin
        bit_r <= 6'h00;
        blk_r <= (blk_r == `T2F_LAST_BLK) ? 3'h0 : blk_r + 3'h1;
      end else begin
        bit_r <= bit_r + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sub_r <= 2'h0;
    end else if (state_r == t2f_pkg::T2F_MSYNC && is_m && !m_ok) begin
      sub_r <= rx_data_i ? 2'h1 : 2'h0;
    end else if (!slip && bit_r == `T2F_LAST_BIT && blk_r == `T2F_LAST_BLK) begin
      sub_r <= sub_r + 2'h1;
    end
  end

  // Misses are counted only while looking for the M pattern.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      miss_r <= 8'h00;
    end else if (state_r != t2f_pkg::T2F_MSYNC) begin
      miss_r <= 8'h00;
    end else if (is_m && !m_ok) begin
      miss_r <= miss_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= t2f_pkg::T2F_HUNT;
      cnt_r      <= 8'h00;
      lof_o      <= 1'b0;
      in_frame_o <= 1'b0;
    end else begin
      lof_o <= 1'b0;
      unique case (state_r)
        t2f_pkg::T2F_HUNT: begin
          if (is_f) begin
            if (!f_ok) begin
              cnt_r <= 8'h00;
            end else if (cnt_r == 8'(FIND_CNT - 1)) begin
              cnt_r   <= 8'h00;
              state_r <= t2f_pkg::T2F_MSYNC;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
        end
        t2f_pkg::T2F_MSYNC: begin
          if (is_f && !f_ok) begin
            cnt_r   <= 8'h00;
            state_r <= t2f_pkg::T2F_HUNT;
          end else if (is_m) begin
            if (!m_ok) begin
              cnt_r <= 8'h00;
              if (give_up) begin
                state_r <= t2f_pkg::T2F_HUNT;
              end
            end else if (cnt_r == 8'(M_FIND_CNT - 1)) begin
              cnt_r      <= 8'h00;
              state_r    <= t2f_pkg::T2F_SYNC;
              in_frame_o <= 1'b1;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
        end
        t2f_pkg::T2F_SYNC: begin
          if ((is_f && !f_ok) || (is_m && !m_ok)) begin
            if (cnt_r == 8'(LOSS_CNT - 1)) begin
              cnt_r   <= 8'h00;
              state_r    <= t2f_pkg::T2F_HUNT;
              lof_o      <= 1'b1;
              in_frame_o <= 1'b0;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end else if (is_f) begin
            cnt_r <= 8'h00;
          end
        end
        default: begin
          state_r    <= t2f_pkg::T2F_HUNT;
          cnt_r      <= 8'h00;
          in_frame_o <= 1'b0;
        end
      endcase
    end
  end

  assign bit_o      = bit_r;
  assign blk_o      = blk_r;
  assign sub_o      = sub_r;
endmodule
`default_nettype wire

/* File: logic/t2f_framer.sv */
// T2 M-frame framer and deframer for four bit-interleaved T1 tributaries.
`timescale 1ns/10ps
`default_nettype none
`include "t2f_defs.svh"
module t2f_framer #(
  parameter int FIND_CNT   = `T2F_FIND_CNT,
  parameter int M_FIND_CNT = `T2F_M_FIND_CNT,
  parameter int LOSS_CNT   = `T2F_LOSS_CNT
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [3:0] tx_trib_data_i,
  input  wire logic [3:0] tx_stuff_req_i,
  output logic            tx_data_o,
  output logic            tx_sof_o,
  output logic [3:0]      tx_take_o,
  input  wire logic       rx_data_i,
  output logic [3:0]      rx_trib_data_o,
  output logic [3:0]      rx_trib_valid_o,
  output logic [3:0]      rx_stuffed_o,
  output logic [3:0]      rx_loop_req_o,
  output logic            rx_in_frame_o,
  output logic            rx_lof_o,
  output logic            rx_remote_alarm_o
);
  t2f_pkg::t2f_bit_t tx_bit_r;
  t2f_pkg::t2f_blk_t tx_blk_r;
  t2f_pkg::t2f_sub_t tx_sub_r;
  logic              tx_stuff_r;
  logic [1:0]        tx_slot;
  logic              tx_data_nxt;
  logic [3:0]        tx_take_nxt;
  t2f_pkg::t2f_bit_t rx_bit;
  t2f_pkg::t2f_blk_t rx_blk;
  t2f_pkg::t2f_sub_t rx_sub;
  logic [1:0]        rx_slot;
  logic [1:0]        rx_c_r;
  logic              rx_stuff_r;
  logic              rx_vote;
  logic              rx_loop;
  logic              rx_is_stuff;
  logic              tx_at_stuff;
  logic              rx_at_stuff;

  // Transmit position: bit within block, block within subframe, subframe.
  // Reset parks it at frame start, so the first bit after release is M1.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_bit_r <= 6'h00;
      tx_blk_r <= 3'h0;
      tx_sub_r <= 2'h0;
    end else if (tx_bit_r == `T2F_LAST_BIT) begin
      tx_bit_r <= 6'h00;
      if (tx_blk_r == `T2F_LAST_BLK) begin
        tx_blk_r <= 3'h0;
        tx_sub_r <= tx_sub_r + 2'h1;
      end else begin
        tx_blk_r <= tx_blk_r + 3'h1;
      end
    end else begin
      tx_bit_r <= tx_bit_r + 6'h01;
    end
  end

  // The stuff request is taken at the M bit so C bits and stuff bit agree all subframe.
  // A request that changes later in the subframe waits for the next frame.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_stuff_r <= 1'b0;
    end else if (tx_bit_r == 6'h00 && tx_blk_r == `T2F_BLK_M) begin
      tx_stuff_r <= tx_stuff_req_i[tx_sub_r];
    end
  end

  // Payload bit p of a block belongs to tributary p mod 4; p is the bit count less one.
  assign tx_slot = tx_bit_r[1:0] - 2'h1;

  // The stuff bit is one fixed payload bit; matching the slot alone would also
  // hit every later bit of the same tributary in the stuff block.
  assign tx_at_stuff = (tx_blk_r == `T2F_BLK_STUFF) &&
                       (tx_bit_r == {4'h0, tx_sub_r} + 6'h01);

  always_comb begin
    tx_data_nxt = 1'b0;
    tx_take_nxt = 4'h0;
    // Each bit is worked out one cycle ahead and registered below.
    if (tx_bit_r == 6'h00) begin
      unique case (tx_blk_r)
        `T2F_BLK_M: begin
          unique case (tx_sub_r)
            2'h0: tx_data_nxt = `T2F_M1_VAL;
            2'h1: tx_data_nxt = `T2F_M2_VAL;
            2'h2: tx_data_nxt = `T2F_M3_VAL;
            // X reports this side's receiver state to the far end.
            2'h3: tx_data_nxt = rx_in_frame_o;
          endcase
        end
        `T2F_BLK_F1: tx_data_nxt = `T2F_F1_VAL;
        `T2F_BLK_F2: tx_data_nxt = `T2F_F2_VAL;
        `T2F_BLK_C1: tx_data_nxt = tx_stuff_r;
        `T2F_BLK_C2: tx_data_nxt = tx_stuff_r;
        `T2F_BLK_C3: tx_data_nxt = tx_stuff_r;
        default:     tx_data_nxt = 1'b0;
      endcase
    end else if (tx_at_stuff && tx_stuff_r) begin
      tx_data_nxt = `T2F_STUFF_VAL;
    end else begin
      // Tributaries two and four travel inverted.
      tx_data_nxt          = tx_trib_data_i[tx_slot] ^ tx_slot[0];
      tx_take_nxt[tx_slot] = 1'b1;
    end
  end

  // Every transmit output is registered, so the line sees one fixed cycle of latency.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_data_o <= 1'b0;
      tx_sof_o  <= 1'b0;
      tx_take_o <= 4'h0;
    end else begin
      tx_data_o <= tx_data_nxt;
      tx_sof_o  <= (tx_bit_r == 6'h00) && (tx_blk_r == 3'h0) && (tx_sub_r == 2'h0);
      tx_take_o <= tx_take_nxt;
    end
  end

  // The aligner alone judges the incoming frame; all receive decoding below
  // follows its bit, block and subframe count.
  t2f_rx_align #(
    .FIND_CNT   (FIND_CNT),
    .M_FIND_CNT (M_FIND_CNT),
    .LOSS_CNT   (LOSS_CNT)
  ) u_align (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .rx_data_i  (rx_data_i),
    .bit_o      (rx_bit),
    .blk_o      (rx_blk),
    .sub_o      (rx_sub),
    .in_frame_o (rx_in_frame_o),
    .lof_o      (rx_lof_o)
  );

  // Receive slot numbering mirrors the transmit side.
  assign rx_slot = rx_bit[1:0] - 2'h1;
  // At C3 the first two C bits are held and the third is on the line.
  // A corrupted C1 or C2 is outvoted; a corrupted C3 after two equal C bits reads as a loopback code instead.
  assign rx_vote = (rx_c_r[0] & rx_c_r[1]) | (rx_c_r[0] & rx_data_i) |
                   (rx_c_r[1] & rx_data_i);
  assign rx_loop = (rx_c_r[0] == rx_c_r[1]) && (rx_data_i != rx_c_r[0]);
  // Only the one payload bit numbered by the subframe can be a stuff bit.
  assign rx_at_stuff = (rx_blk == `T2F_BLK_STUFF) &&
                       (rx_bit == {4'h0, rx_sub} + 6'h01);
  assign rx_is_stuff = rx_at_stuff && rx_stuff_r;

  // Received C bits and the stuff decision for the current subframe.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_c_r        <= 2'h0;
      rx_stuff_r    <= 1'b0;
      rx_loop_req_o <= 4'h0;
    end else begin
      rx_loop_req_o <= 4'h0;
      if (rx_bit == 6'h00) begin
        if (rx_blk == `T2F_BLK_M) begin
          // Clearing at the M bit keeps a stale decision out of the next stuff block.
          rx_stuff_r <= 1'b0;
        end else if (rx_blk == `T2F_BLK_C1) begin
          rx_c_r[0] <= rx_data_i;
        end else if (rx_blk == `T2F_BLK_C2) begin
          rx_c_r[1] <= rx_data_i;
        end else if (rx_blk == `T2F_BLK_C3) begin
          // A loopback code carries no stuff; the slot is kept as data.
          rx_stuff_r <= rx_vote && !rx_loop;
          rx_loop_req_o[rx_sub] <= rx_loop && rx_in_frame_o;
        end
      end
    end
  end

  // Payload demultiplex; nothing is delivered while out of frame.
  // Data holds between valid pulses; the pulse, not the level, marks a new bit.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_trib_data_o  <= 4'h0;
      rx_trib_valid_o <= 4'h0;
      rx_stuffed_o    <= 4'h0;
    end else begin
      rx_trib_valid_o <= 4'h0;
      rx_stuffed_o    <= 4'h0;
      if (rx_in_frame_o && rx_bit != 6'h00) begin
        if (rx_is_stuff) begin
          rx_stuffed_o[rx_slot] <= 1'b1;
        end else begin
          rx_trib_data_o[rx_slot]  <= rx_data_i ^ rx_slot[0];
          rx_trib_valid_o[rx_slot] <= 1'b1;
        end
      end
    end
  end

  // Far-end alarm: a received X bit of zero means the far end lost frame.
  // It is held low out of frame, since the X position is unknown then.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_remote_alarm_o <= 1'b0;
    end else if (!rx_in_frame_o) begin
      rx_remote_alarm_o <= 1'b0;
    end else if (rx_bit == 6'h00 && rx_blk == `T2F_BLK_M && rx_sub == `T2F_LAST_SUB) begin
      rx_remote_alarm_o <= ~rx_data_i;
    end
  end
endmodule
`default_nettype wire

/* File: verification/t2f_framer_sva.sv */
// Port checker for the T2 M-frame framer, bound onto the top module.
`timescale 1ns/10ps
`default_nettype none
module t2f_framer_sva (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic [3:0] tx_stuff_req_i,
  input wire logic       tx_data_o,
  input wire logic       tx_sof_o,
  input wire logic [3:0] tx_take_o,
  input wire logic [3:0] rx_trib_valid_o,
  input wire logic [3:0] rx_stuffed_o,
  input wire logic [3:0] rx_loop_req_o,
  input wire logic       rx_in_frame_o,
  input wire logic       rx_lof_o
);
  logic [10:0] cnt_r;
  logic        seen_r;
  logic [3:0]  sreq_r;
  logic        cs_r;
  logic [10:0] pos;
  logic [5:0]  b;
  logic [2:0]  k;
  logic [1:0]  s;
  logic        ovh;
  logic        slot;
  // Position of the bit now on tx_data_o, counted from the last frame start.
  assign pos = tx_sof_o ? 11'h0 : cnt_r;
  assign b = 6'(pos % 49);
  assign k = 3'((pos / 49) % 6);
  assign s = 2'(pos / 294);
  assign ovh = seen_r && b == 6'h0;
  assign slot = seen_r && k == 3'h5 && b == 6'(s) + 6'h1;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r  <= 11'h0;
      seen_r <= 1'b0;
    end else begin
      cnt_r  <= tx_sof_o ? 11'h1 : cnt_r + 11'h1;
      seen_r <= seen_r | tx_sof_o;
    end
  end
  // The request is sampled on the edge that builds the M bit, so keep a delayed copy.
  always_ff @(posedge clk_i) begin
    sreq_r <= tx_stuff_req_i;
    if (ovh && k == 3'h0)
      cs_r <= sreq_r[s];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_drop;
    ##[0:1] !rx_in_frame_o;
  endsequence
  property p_sof; seen_r |-> tx_sof_o == (cnt_r == 11'd1176); endproperty
  a_sof: assert property (p_sof) else $error("frame start spacing wrong");
  property p_m1; tx_sof_o |-> !tx_data_o && tx_take_o == 4'h0; endproperty
  a_m1: assert property (p_m1) else $error("first M bit wrong");
  property p_m; ovh && k == 3'h0 && s != 2'h3 |-> tx_data_o == (s != 2'h0); endproperty
  a_m: assert property (p_m) else $error("M bit wrong");
  property p_f; ovh && (k == 3'h2 || k == 3'h5) |-> tx_data_o == (k == 3'h5); endproperty
  a_f: assert property (p_f) else $error("F bit wrong");
  property p_c; ovh && (k == 3'h1 || k == 3'h3 || k == 3'h4) |-> tx_data_o == cs_r; endproperty
  a_c: assert property (p_c) else $error("C bit wrong");
  property p_take;
    seen_r && !slot |-> tx_take_o == (b == 6'h0 ? 4'h0 : 4'h1 << 2'(b - 6'h1));
  endproperty
  a_take: assert property (p_take) else $error("payload slot order wrong");
  property p_slot;
    slot |-> (cs_r ? !tx_data_o && tx_take_o == 4'h0 : tx_take_o == 4'h1 << s);
  endproperty
  a_slot: assert property (p_slot) else $error("stuff slot wrong");
  property p_x;
    ovh && k == 3'h0 && s == 2'h3 |->
      tx_data_o == $past(rx_in_frame_o);
  endproperty
  a_x: assert property (p_x) else $error("X bit wrong");
  property p_quiet;
    !rx_in_frame_o && !$past(rx_in_frame_o) |->
      (rx_trib_valid_o | rx_stuffed_o | rx_loop_req_o) == 4'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output while out of frame");
  property p_lof; rx_lof_o |-> s_drop; endproperty
  a_lof: assert property (p_lof) else $error("frame kept after loss");
  property p_excl; (rx_stuffed_o & rx_loop_req_o) == 4'h0; endproperty
  a_excl: assert property (p_excl) else $error("stuff on loopback code");
endmodule
bind t2f_framer t2f_framer_sva t2f_framer_sva_i (.clk_i, .reset_i, .tx_stuff_req_i,
  .tx_data_o, .tx_sof_o, .tx_take_o, .rx_trib_valid_o, .rx_stuffed_o, .rx_loop_req_o,
  .rx_in_frame_o, .rx_lof_o);
`default_nettype wire

/* File: verification/t2f_far_end.sv */
// Far-end T2 source model that feeds the receiver.
`timescale 1ns/10ps
`default_nettype none
module t2f_far_end (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [3:0] val_i,
  input  wire logic [2:0] code_i,
  input  wire logic       x_i,
  input  wire logic       bad_i,
  output logic            data_o
);
  logic [10:0] pos_r;
  logic [5:0]  b;
  logic [2:0]  k;
  logic [1:0]  s;
  logic        m;
  logic        lp;
  logic        st;
  logic [5:0]  oh;
  assign b = 6'(pos_r % 49);
  assign k = 3'((pos_r / 49) % 6);
  assign s = 2'(pos_r / 294);
  assign m = (s == 2'h3) ? x_i : (s != 2'h0);
  // Bad framing flips both F bits so the receiver sees a clean loss.
  assign oh = {!bad_i, code_i[2:1], bad_i, code_i[0], m};
  assign lp = code_i[0] == code_i[1] && code_i[2] != code_i[0];
  assign st = $countones(code_i) >= 2 && !lp;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pos_r  <= 11'h0;
      data_o <= 1'b0;
    end else begin
      pos_r <= (pos_r == 11'd1175) ? 11'h0 : pos_r + 11'h1;
      if (b == 6'h0)
        data_o <= oh[k];
      else if (k == 3'h5 && b == 6'(s) + 6'h1 && st)
        data_o <= 1'b0;
      else
        data_o <= val_i[2'(b - 6'h1)] ^ !b[0];
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking testbench of the T2 M-frame framer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  logic clk, reset, tx_data, tx_sof, rx_data, in_frame, lof, ralarm, x, bad;
  logic [3:0] trib, sreq, take, rx_trib, rx_valid, rx_st, rx_lp, prev, val;
  logic [2:0] code;
  int n_errors, checks, cyc, n_st, n_lp, s0, l0;
  t2f_framer t2f_framer_i (.clk_i(clk), .reset_i(reset), .tx_trib_data_i(trib),
    .tx_stuff_req_i(sreq), .tx_data_o(tx_data), .tx_sof_o(tx_sof), .tx_take_o(take),
    .rx_data_i(rx_data), .rx_trib_data_o(rx_trib), .rx_trib_valid_o(rx_valid),
    .rx_stuffed_o(rx_st), .rx_loop_req_o(rx_lp), .rx_in_frame_o(in_frame),
    .rx_lof_o(lof), .rx_remote_alarm_o(ralarm));
  t2f_far_end t2f_far_end_i (.clk_i(clk), .reset_i(reset), .val_i(val), .code_i(code),
    .x_i(x), .bad_i(bad), .data_o(rx_data));
  function automatic int exp_cnt(input logic [2:0] c, input bit lp);
    bit l = c[0] == c[1] && c[2] != c[0];
    bit m = $countones(c) >= 2;
    return (lp ? l : m && !l) ? 4 : 0;
  endfunction
  task automatic complete_run();
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_in(input logic want);
    for (int i = 0; i < 12000 && in_frame !== want; i++) @(negedge clk);
    `CHK("in_frame", want, in_frame)
  endtask
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    prev <= trib;
    trib <= 4'($urandom);
    if (tx_sof === 1'b1) sreq <= 4'($urandom);
    n_st += $countones(rx_st);
    n_lp += $countones(rx_lp);
    // Worst case hunting plus all scenarios stays well below this ceiling.
    if (cyc > 90000) begin
      n_errors++;
      complete_run();
    end
  end
  always @(negedge clk)
    for (int k = 0; k < 4; k++)
      if (!reset && take[k] === 1'b1) `CHK("tx_payload", prev[k] ^ (k % 2 == 1), tx_data)
  initial begin
    clk = 0; reset = 1; trib = 0; sreq = 0; val = 0; code = 0; x = 1; bad = 0;
    n_errors = 0; checks = 0; cyc = 0; n_st = 0; n_lp = 0;
    void'($urandom(32'h8141d711));
    repeat (5) @(posedge clk);
    reset <= 0;
    wait_in(1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      val <= (i == 0) ? 4'ha : (i == 1) ? 4'h5 : 4'($urandom);
      repeat (300) @(negedge clk);
      `CHK("rx_trib", val, rx_trib)
    end
    @(posedge clk);
    x <= 0;
    repeat (2400) @(negedge clk);
    `CHK("remote_alarm", 1'b1, ralarm)
    @(posedge clk);
    x <= 1;
    repeat (2400) @(negedge clk);
    `CHK("remote_alarm", 1'b0, ralarm)
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      code <= 3'(c);
      repeat (1200) @(posedge clk);
      // The counters move at the rising edge, so window ends are read at the falling one.
      @(negedge clk);
      s0 = n_st;
      l0 = n_lp;
      repeat (1176) @(negedge clk);
      `CHK("stuffed", exp_cnt(3'(c), 0), n_st - s0)
      `CHK("loop_req", exp_cnt(3'(c), 1), n_lp - l0)
    end
    @(posedge clk);
    code <= 0;
    bad <= 1;
    for (int i = 0; i < 1500 && lof !== 1'b1; i++) @(negedge clk);
    `CHK("lof", 1'b1, lof)
    wait_in(1'b0);
    // Clearing the fault before the next F check keeps the aligner on the true position.
    @(posedge clk);
    bad <= 0;
    wait_in(1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
